/* File: hdl/mailbox_regs.svh */
/*
  Constants of the network slave mailbox: slot offsets in the mailboxes, coordination
  byte bit positions, reset values and address limits.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef MAILBOX_REGS_SVH
`define MAILBOX_REGS_SVH

// ----------------------------------------------------------------------------
// Mailbox layout
// ----------------------------------------------------------------------------
`define MBOX_DEPTH   66
`define MBOX_AW      7
`define SLOT_LEN     7'h00
`define SLOT_DEST    7'h01
`define SLOT_DATA    7'h02
`define MAX_PAYLOAD  8'h40
`define DEST_MASTER  5'h00
`define DEST_BCAST   5'h1f
`define DEST_MSB     4

// ----------------------------------------------------------------------------
// Coordination bytes
// ----------------------------------------------------------------------------
`define SEND_REQ_BIT   7
`define SEND_EXPR_BIT  4
`define SEND_ERR_BIT   0
`define RECV_READY_BIT 7
`define RECV_EXPR_BIT  4
`define HDR_EXPR     7
`define KB_RESET     8'h00
`define BYTE_ZERO    8'h00

`endif

/* File: hdl/mailbox_pkg.sv */
/*
  Types shared by the network slave mailbox modules.
  Assumes mailbox_regs.svh is on the include path.
*/
package mailbox_pkg;
  `include "mailbox_regs.svh"

  // --------------------------------------------------------------------------
  // Transmit sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR  = 3'b001,
    S_LEN  = 3'b010,
    S_DATA = 3'b011,
    S_ACK  = 3'b100
  } tx_state_t;
endpackage

/* File: hdl/mbox_port_if.sv */
/*
  Port bundle between the mailbox owner logic and one mailbox byte store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface mbox_port_if #(parameter int AW = 7);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: hdl/mailbox_store.sv */
/*
  One mailbox byte store: synchronous write, combinational read.
  Assumes the owner keeps write addresses below DEPTH.
*/
`timescale 1ns/1ps
module mailbox_store #(
  parameter int DEPTH = 66,
  parameter int AW    = 7
) (
  input  wire logic clk_sys_i,
  mbox_port_if.store mb
);
  logic [7:0] mem [DEPTH];

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // No reset on the array: contents are only meaningful after a fill
  always_ff @(posedge clk_sys_i) begin
    if (mb.wr_en) begin
      mem[mb.wr_addr] <= mb.wr_data;
    end
  end

  // Read returns zero beyond the last slot
  assign mb.rd_data = (int'(mb.rd_addr) < DEPTH) ? mem[mb.rd_addr] : 8'h00;
endmodule

/* File: hdl/network_slave_mailbox.sv */
/*
  Slave-side message exchange: send mailbox with send coordination byte, receive
  mailbox with receive coordination byte, and a byte-stream link to the line interface.
  Assumes the link signals come from logic on clk_sys_i and that the line interface
  raises net_poll_i when the master grants this slave a send slot.
*/
`timescale 1ns/1ps
`include "mailbox_regs.svh"
module network_slave_mailbox
  import mailbox_pkg::*;
#(
  parameter int DEPTH = `MBOX_DEPTH,
  parameter int AW    = `MBOX_AW
) (
  input  wire logic          clk_sys_i,
  input  wire logic          srst_i,
  input  wire logic          cp_wr_i,
  input  wire logic [AW-1:0] cp_addr_i,
  input  wire logic [7:0]    cp_wdata_i,
  input  wire logic          cp_coord_wr_i,
  input  wire logic [7:0]    cp_coord_data_i,
  input  wire logic [AW-1:0] cp_rx_addr_i,
  input  wire logic          cp_rx_release_i,
  output logic      [7:0]    send_coord_o,
  output logic      [7:0]    recv_coord_o,
  output logic      [7:0]    rx_rd_data_o,
  input  wire logic          net_poll_i,
  input  wire logic          tx_ready_i,
  input  wire logic          net_ack_i,
  input  wire logic          net_nak_i,
  output logic               tx_valid_o,
  output logic      [7:0]    tx_data_o,
  output logic               tx_last_o,
  output logic               tx_pending_o,
  output logic               tx_express_o,
  input  wire logic          rx_valid_i,
  input  wire logic [7:0]    rx_data_i,
  input  wire logic          rx_last_i,
  output logic               rx_busy_o
);
  mbox_port_if #(.AW(AW)) tx_mb ();
  mbox_port_if #(.AW(AW)) rx_mb ();

  tx_state_t     state_reg;
  logic [7:0]    send_coord_reg;
  logic [7:0]    recv_coord_reg;
  logic [7:0]    send_len_reg;
  logic [4:0]    send_dest_reg;
  logic [AW-1:0] tx_idx_reg;
  logic [AW-1:0] rx_cnt_reg;
  logic          rx_in_frame_reg;
  logic          rx_take_reg;
  logic          rx_over_reg;

  // ----------------------------------------------------------------------------
  // Mailbox stores
  // ----------------------------------------------------------------------------
  mailbox_store #(.DEPTH(DEPTH), .AW(AW)) send_store (
    .clk_sys_i (clk_sys_i),
    .mb        (tx_mb.store)
  );
  mailbox_store #(.DEPTH(DEPTH), .AW(AW)) recv_store (
    .clk_sys_i (clk_sys_i),
    .mb        (rx_mb.store)
  );

  // ----------------------------------------------------------------------------
  // Send side decode
  // ----------------------------------------------------------------------------
  // Mailbox is locked while a request is pending, so the frame cannot change mid-send
  wire       send_busy = send_coord_reg[`SEND_REQ_BIT];
  wire       cp_fill   = cp_wr_i && !send_busy;
  wire       len_bad   = (send_len_reg == `BYTE_ZERO) || (send_len_reg > `MAX_PAYLOAD);
  wire [7:0] hdr_byte  = {send_coord_reg[`SEND_EXPR_BIT], 2'b00, send_dest_reg};
  wire       tx_adv    = tx_valid_o && tx_ready_i;
  wire       data_done = ({1'b0, tx_idx_reg} == send_len_reg);
  wire       next_last = ({1'b0, tx_idx_reg} + 8'h01 == send_len_reg);
  wire       tx_finish = (state_reg == S_ACK) && (net_ack_i || net_nak_i);
  wire       tx_reject = (state_reg == S_IDLE) && send_busy && len_bad;

  assign tx_mb.wr_en   = cp_fill;
  assign tx_mb.wr_addr = cp_addr_i;
  assign tx_mb.wr_data = cp_wdata_i;
  assign tx_mb.rd_addr = `SLOT_DATA + tx_idx_reg;

  // Length and destination shadowed so the header needs no extra read port
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      send_len_reg  <= `KB_RESET;
      send_dest_reg <= `DEST_MASTER;
    end else if (cp_fill && cp_addr_i == `SLOT_LEN) begin
      send_len_reg  <= cp_wdata_i;
    end else if (cp_fill && cp_addr_i == `SLOT_DEST) begin
      send_dest_reg <= cp_wdata_i[`DEST_MSB:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Send coordination byte
  // ----------------------------------------------------------------------------
  // Program writes are ignored while busy; the hardware clear can never collide with one
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      send_coord_reg <= `KB_RESET;
    end else if (tx_finish || tx_reject) begin
      send_coord_reg[`SEND_REQ_BIT] <= 1'b0;
      send_coord_reg[`SEND_ERR_BIT] <= net_nak_i || tx_reject;
    end else if (cp_coord_wr_i && !send_busy) begin
      send_coord_reg <= cp_coord_data_i & ((8'h01 << `SEND_REQ_BIT) | (8'h01 << `SEND_EXPR_BIT));
    end
  end

  // ----------------------------------------------------------------------------
  // Transmit sequencer: header, length, payload, then wait for the line verdict
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg  <= S_IDLE;
      tx_valid_o <= 1'b0;
      tx_data_o  <= `BYTE_ZERO;
      tx_last_o  <= 1'b0;
      tx_idx_reg <= '0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (send_busy && !len_bad && net_poll_i) begin
            tx_valid_o <= 1'b1;
            tx_data_o  <= hdr_byte;
            state_reg  <= S_HDR;
          end
        end
        S_HDR: begin
          if (tx_adv) begin
            tx_data_o <= send_len_reg;
            state_reg <= S_LEN;
          end
        end
        S_LEN: begin
          if (tx_adv) begin
            tx_data_o  <= tx_mb.rd_data;
            tx_last_o  <= next_last;
            tx_idx_reg <= tx_idx_reg + 1'b1;
            state_reg  <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_adv && data_done) begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            state_reg  <= S_ACK;
          end else if (tx_adv) begin
            tx_data_o  <= tx_mb.rd_data;
            tx_last_o  <= next_last;
            tx_idx_reg <= tx_idx_reg + 1'b1;
          end
        end
        S_ACK: begin
          tx_idx_reg <= '0;
          if (tx_finish) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg  <= S_IDLE;
          tx_valid_o <= 1'b0;
        end
      endcase
    end
  end

  // Express requests tell the line interface to claim the next slot first
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_pending_o <= 1'b0;
      tx_express_o <= 1'b0;
    end else begin
      tx_pending_o <= send_busy;
      tx_express_o <= send_busy && send_coord_reg[`SEND_EXPR_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // Receive side decode
  // ----------------------------------------------------------------------------
  // Frame byte 0 is the source, byte 1 the length; swapped into mailbox slots 1 and 0
  wire          rx_ready = recv_coord_reg[`RECV_READY_BIT];
  wire          rx_take  = rx_in_frame_reg ? rx_take_reg : rx_ready;
  wire          rx_fits  = int'(rx_cnt_reg) < DEPTH;
  wire          rx_we    = rx_valid_i && rx_take && rx_fits;
  wire          rx_done  = rx_valid_i && rx_last_i && rx_take && rx_fits && !rx_over_reg;
  wire [AW-1:0] rx_slot  = (rx_cnt_reg == `SLOT_LEN) ? `SLOT_DEST :
                           (rx_cnt_reg == `SLOT_DEST) ? `SLOT_LEN : rx_cnt_reg;

  assign rx_mb.wr_en   = rx_we;
  assign rx_mb.wr_addr = rx_slot;
  assign rx_mb.wr_data = (rx_cnt_reg == `SLOT_LEN) ? {3'b000, rx_data_i[`DEST_MSB:0]} : rx_data_i;
  assign rx_mb.rd_addr = cp_rx_addr_i;

  // Frame tracking; an overlong frame is dropped so the mailbox never shows a cut message
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_cnt_reg      <= '0;
      rx_in_frame_reg <= 1'b0;
      rx_take_reg     <= 1'b0;
      rx_over_reg     <= 1'b0;
    end else if (rx_valid_i && rx_last_i) begin
      rx_cnt_reg      <= '0;
      rx_in_frame_reg <= 1'b0;
      rx_over_reg     <= 1'b0;
    end else if (rx_valid_i) begin
      rx_cnt_reg      <= rx_fits ? rx_cnt_reg + 1'b1 : rx_cnt_reg;
      rx_in_frame_reg <= 1'b1;
      rx_take_reg     <= rx_take;
      rx_over_reg     <= rx_over_reg || !rx_fits;
    end
  end

  // ----------------------------------------------------------------------------
  // Receive coordination byte and read port
  // ----------------------------------------------------------------------------
  // Master and slave sources take the same path; the source number is only stored
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      recv_coord_reg <= `KB_RESET;
    end else if (rx_done) begin
      recv_coord_reg[`RECV_READY_BIT] <= 1'b0;
    end else if (cp_rx_release_i) begin
      recv_coord_reg[`RECV_READY_BIT] <= 1'b1;
    end
    if (!srst_i && rx_we && rx_cnt_reg == `SLOT_LEN) begin
      recv_coord_reg[`RECV_EXPR_BIT] <= rx_data_i[`HDR_EXPR];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_rd_data_o <= `BYTE_ZERO;
      rx_busy_o    <= 1'b1;
    end else begin
      rx_rd_data_o <= rx_mb.rd_data;
      rx_busy_o    <= !recv_coord_reg[`RECV_READY_BIT] || rx_done;
    end
  end

  assign send_coord_o = send_coord_reg;
  assign recv_coord_o = recv_coord_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence hdr_taken_s;
    state_reg == S_HDR && tx_adv;
  endsequence

  idle_no_poll_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (state_reg == S_IDLE && !net_poll_i) |=> !tx_valid_o)
    else $error("frame started without a poll");
  len_follows_hdr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    hdr_taken_s |=> tx_valid_o && tx_data_o == send_len_reg && send_len_reg <= `MAX_PAYLOAD)
    else $error("length byte wrong after header");
  rx_bounded_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rx_we |-> int'(rx_slot) < DEPTH)
    else $error("receive write beyond mailbox");
  busy_locks_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    send_busy |-> !tx_mb.wr_en ##1 $stable(send_len_reg))
    else $error("send mailbox changed while busy");
  done_clears_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tx_finish |=> !send_coord_o[`SEND_REQ_BIT] && state_reg == S_IDLE)
    else $error("request not dropped after send");
  nak_error_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tx_finish && net_nak_i) |=> send_coord_o[`SEND_ERR_BIT] ##1 (send_coord_o[`SEND_ERR_BIT] || send_busy))
    else $error("error flag not set on failed send");
  hdr_fields_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(tx_valid_o) |-> tx_data_o[`HDR_EXPR] == send_coord_reg[`SEND_EXPR_BIT]
                          && tx_data_o[`DEST_MSB:0] == send_dest_reg)
    else $error("header express or destination wrong");
  rx_ready_drop_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rx_done |=> !recv_coord_o[`RECV_READY_BIT] ##1 rx_busy_o)
    else $error("ready flag not cleared on arrival");
  rx_protect_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!rx_ready && !rx_in_frame_reg) |-> !rx_mb.wr_en)
    else $error("receive mailbox overwritten while not ready");
  release_sets_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cp_rx_release_i && !rx_done) |=> recv_coord_o[`RECV_READY_BIT])
    else $error("release did not restore readiness");
endmodule

/* File: testbench/link_partner.sv */
/*
  Behavioural line interface facing the mailbox: grants send slots,
  accepts bytes with optional stalls, records them and returns a verdict.
  Assumes it shares clk_sys_i with the block and is steered by the bench.
*/
`timescale 1ns/1ps
module link_partner (
  input  wire logic       clk_sys_i,
  input  wire logic       poll_en_i,
  input  wire logic       slow_i,
  input  wire logic       nak_mode_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            net_poll_o,
  output logic            tx_ready_o,
  output logic            net_ack_o,
  output logic            net_nak_o
);
  logic [7:0] cap [0:255];
  int         n       = 0;
  int         last_at = 0;
  int         ack_cnt = 0;
  logic       ph      = 1'b0;
  logic       ack_q   = 1'b0;
  logic       nak_q   = 1'b0;

  // Slot grant only when the bench says so; stalls on every other cycle while slow_i is set
  assign net_poll_o = poll_en_i;
  assign tx_ready_o = !slow_i || ph;
  assign net_ack_o  = ack_q;
  assign net_nak_o  = nak_q;

  // Capture, and a verdict pulse three cycles after the last byte
  always @(posedge clk_sys_i) begin
    ph <= !ph;
    ack_q <= 1'b0;
    nak_q <= 1'b0;
    if (ack_cnt > 0) ack_cnt <= ack_cnt - 1;
    if (ack_cnt == 1) begin
      ack_q <= !nak_mode_i;
      nak_q <= nak_mode_i;
    end
    if (tx_valid_i && tx_ready_o) begin
      cap[n[7:0]] <= tx_data_i;
      n <= n + 1;
      if (tx_last_i) begin
        last_at <= n;
        ack_cnt <= 3;
      end
    end
  end
endmodule

/* File: testbench/tb.sv */
/*
  Self-checking bench of the network slave mailbox: send, refusal and receive.
  Assumes link_partner on the transmit side; receive bytes come from the bench.
*/
`timescale 1ns/1ps
module tb;
  import mailbox_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       cp_wr_i = 1'b0;
  logic [6:0] cp_addr_i = 7'h00;
  logic [7:0] cp_wdata_i = 8'h00;
  logic       cp_coord_wr_i = 1'b0;
  logic [7:0] cp_coord_data_i = 8'h00;
  logic [6:0] cp_rx_addr_i = 7'h00;
  logic       cp_rx_release_i = 1'b0;
  logic       rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic       rx_last_i = 1'b0;
  logic       poll_en = 1'b0;
  logic       slow_mode = 1'b0;
  logic       nak_mode = 1'b0;
  logic       net_poll_i, tx_ready_i, net_ack_i, net_nak_i;
  logic [7:0] send_coord_o, recv_coord_o, rx_rd_data_o, tx_data_o;
  logic       tx_valid_o, tx_last_o, tx_pending_o, tx_express_o, rx_busy_o;
  int         errors = 0;
  int         n_tests = 0;
  int         base;

  network_slave_mailbox i_dut (.clk_sys_i, .srst_i, .cp_wr_i, .cp_addr_i, .cp_wdata_i, .cp_coord_wr_i,
    .cp_coord_data_i, .cp_rx_addr_i, .cp_rx_release_i, .send_coord_o, .recv_coord_o, .rx_rd_data_o,
    .net_poll_i, .tx_ready_i, .net_ack_i, .net_nak_i, .tx_valid_o, .tx_data_o, .tx_last_o,
    .tx_pending_o, .tx_express_o, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_busy_o);
  link_partner i_link (.clk_sys_i, .poll_en_i(poll_en), .slow_i(slow_mode), .nak_mode_i(nak_mode),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .net_poll_o(net_poll_i),
    .tx_ready_o(tx_ready_i), .net_ack_o(net_ack_i), .net_nak_o(net_nak_i));

  // ----------------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------------
  initial begin
    forever #5 clk_sys_i = !clk_sys_i;
  end
  // Inputs move 1 ns after the edge, clear of the sampling instant
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Strobe dropped for a cycle so back-to-back calls never collide
  task automatic wr_slot(input logic [6:0] a, input logic [7:0] d);
    cp_wr_i = 1'b1;
    cp_addr_i = a;
    cp_wdata_i = d;
    tick;
    cp_wr_i = 1'b0;
    tick;
  endtask
  task automatic coord_wr(input logic [7:0] v);
    cp_coord_wr_i = 1'b1;
    cp_coord_data_i = v;
    tick;
    cp_coord_wr_i = 1'b0;
  endtask
  task automatic rd_rx(input logic [6:0] a, input logic [7:0] mask, input logic [7:0] exp);
    cp_rx_addr_i = a;
    tick;
    check(rx_rd_data_o & mask, exp);
  endtask
  task automatic release_rx;
    cp_rx_release_i = 1'b1;
    tick;
    cp_rx_release_i = 1'b0;
    tick;
  endtask
  // Byte k of a frame from k = 2 on carries seed+k; data idles inverted after the frame
  task automatic rx_frame(input logic [7:0] hdr, input logic [7:0] len, input logic [7:0] seed);
    for (int k = 0; k < len + 2; k++) begin
      rx_valid_i = 1'b1;
      rx_data_i = (k == 0) ? hdr : (k == 1) ? len : seed + k[7:0];
      rx_last_i = (k == len + 1);
      tick;
    end
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    rx_data_i = ~rx_data_i;
    tick;
  endtask
  // Full send: fill, request, refused meddling, grant, frame and verdict
  task automatic send_test(input logic [7:0] len, input logic [4:0] dest, input logic [7:0] coord,
                           input logic slow, input logic nak);
    base = i_link.n;
    slow_mode = slow;
    nak_mode = nak;
    wr_slot(7'h00, len);
    wr_slot(7'h01, {3'b000, dest});
    for (int k = 0; k < len; k++) wr_slot(7'h02 + k[6:0], 8'h30 + k[7:0]);
    coord_wr(coord);
    check(send_coord_o, coord & 8'h90);
    tick;
    tick;
    check({6'h00, tx_pending_o, tx_express_o}, {6'h00, 1'b1, coord[4]});
    wr_slot(7'h02, 8'hee);
    coord_wr(8'h00);
    tick;
    check(send_coord_o, coord & 8'h90);
    check({7'h00, tx_valid_o}, 8'h00);
    poll_en = 1'b1;
    for (int i = 0; i < 2000 && send_coord_o[7] !== 1'b0; i++) tick;
    poll_en = 1'b0;
    check(send_coord_o, {3'b000, coord[4], 3'b000, nak});
    check(i_link.cap[base], {coord[4], 2'b00, dest});
    check(i_link.cap[base+1], len);
    for (int k = 0; k < len; k++) check(i_link.cap[base+2+k], 8'h30 + k[7:0]);
    check(i_link.last_at[7:0], base[7:0] + len + 8'h01);
  endtask

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (10) tick;
    srst_i = 1'b0;
    check(send_coord_o, 8'h00);
    check(recv_coord_o, 8'h00);
    check({6'h00, rx_busy_o, tx_valid_o}, 8'h02);
    send_test(8'h02, 5'h00, 8'h80, 1'b0, 1'b0);
    send_test(8'h40, 5'h1f, 8'h90, 1'b1, 1'b1);
    send_test(8'h01, 5'h05, 8'h80, 1'b1, 1'b0);
    // Lengths outside 1..64 are refused and flagged, nothing goes out
    for (int i = 0; i < 2; i++) begin
      base = i_link.n;
      wr_slot(7'h00, (i == 0) ? 8'h00 : 8'h41);
      coord_wr(8'h80);
      poll_en = 1'b1;
      repeat (6) tick;
      poll_en = 1'b0;
      check(send_coord_o, 8'h01);
      check(i_link.n[7:0], base[7:0]);
    end
    rx_frame(8'h03, 8'h02, 8'h50);
    check({recv_coord_o[7], 6'h00, rx_busy_o}, 8'h01);
    release_rx;
    check({recv_coord_o[7], 6'h00, rx_busy_o}, 8'h80);
    rx_frame(8'h00, 8'h03, 8'h60);
    check({recv_coord_o[7], recv_coord_o[4], 5'h00, rx_busy_o}, 8'h01);
    rd_rx(7'h00, 8'hff, 8'h03);
    rd_rx(7'h01, 8'h1f, 8'h00);
    for (int k = 2; k < 5; k++) rd_rx(k[6:0], 8'hff, 8'h60 + k[7:0]);
    rx_frame(8'h07, 8'h03, 8'h70);
    rd_rx(7'h02, 8'hff, 8'h62);
    rd_rx(7'h01, 8'h1f, 8'h00);
    release_rx;
    rx_frame(8'h85, 8'h40, 8'h10);
    check({recv_coord_o[7], recv_coord_o[4], 5'h00, rx_busy_o}, 8'h41);
    rd_rx(7'h00, 8'hff, 8'h40);
    rd_rx(7'h01, 8'h1f, 8'h05);
    for (int k = 2; k < 66; k++) rd_rx(k[6:0], 8'hff, 8'h10 + k[7:0]);
    end_sim;
  end

  // Whole run needs some 5 us; forty times that means a hang
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule
